/* File: smc_pkg.sv */
// Constants, types and helpers shared by the supply monitor logic.
`default_nettype none

package smc_pkg;

  // ==========================================================
  // Clocking
  // ==========================================================
  localparam int REF_KHZ = 250000;
  localparam int MCLK_KHZ = 8000;
  localparam int PRESCALE = 32;
  localparam int LOGIC_KHZ = MCLK_KHZ / PRESCALE;

  // Fractional oscillator: add MCLK per ref cycle, wrap at REF
  localparam int OSC_W = 9;
  localparam logic [OSC_W-1:0] OSC_MOD = 9'h0fa;
  localparam logic [OSC_W-1:0] OSC_STEP = 9'h008;
  localparam logic [OSC_W-1:0] OSC_HALF = 9'h07d;

  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_LAST = 5'h1f;
  localparam logic [PRE_W-1:0] PRE_HALF = 5'h10;

  typedef enum logic [1:0] {
    SMC_STANDALONE = 2'b00,
    SMC_MASTER     = 2'b01,
    SMC_SLAVE      = 2'b10,
    SMC_NOSOURCE   = 2'b11
  } smc_mode_e;

  // ==========================================================
  // Monitor channels and filter
  // ==========================================================
  localparam int N_CH = 10;
  localparam int N_DIN = 4;
  localparam int FILT_ON_US = 64;
  localparam int FILT_OFF_US = 16;
  localparam int FILT_W = 5;
  localparam logic [FILT_W-1:0] FILT_ON_TICKS =
    FILT_W'(FILT_ON_US * LOGIC_KHZ / 1000);
  localparam logic [FILT_W-1:0] FILT_OFF_TICKS =
    FILT_W'(FILT_OFF_US * LOGIC_KHZ / 1000);

  // ==========================================================
  // Converter readout
  // ==========================================================
  localparam int SEL_W = 4;
  localparam int ADC_W = 10;
  localparam int RD_W = 12;
  localparam int HI_W = 8;
  localparam int LO_W = 4;
  localparam int MV_PER_COUNT = 2;

  typedef enum logic {
    SMC_ADC_IDLE = 1'b0,
    SMC_ADC_BUSY = 1'b1
  } smc_adc_e;

  // ==========================================================
  // Timers
  // ==========================================================
  localparam int N_TMR = 4;
  localparam int STEP_W = 7;
  localparam int TCNT_W = 21;
  localparam int TMR_MIN_US = 32;
  localparam int TMR_MAX_US = 1960000;
  localparam int TMR_MIN_TICKS = TMR_MIN_US * LOGIC_KHZ / 1000;
  localparam int TMR_MAX_TICKS = TMR_MAX_US / 1000 * LOGIC_KHZ;

  // Step: mantissa in low four bits, exponent in high three
  function automatic logic [TCNT_W-1:0] smc_timeout_ticks(
    input logic [STEP_W-1:0] step
  );
    int t;
    t = (int'(step[3:0]) + 1) * TMR_MIN_TICKS;
    t = t << (2 * int'(step[6:4]));
    if (t > TMR_MAX_TICKS) begin
      t = TMR_MAX_TICKS;
    end
    return t[TCNT_W-1:0];
  endfunction : smc_timeout_ticks

endpackage : smc_pkg

`default_nettype wire

/* File: smc_chan.sv */
// One monitor channel: sampling, digital filter and window select.
`default_nettype none

module smc_chan
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Logic clock tick
  input  wire logic logic_tick,
  // Comparators and configuration
  input  wire logic upper_cmp,
  input  wire logic lower_cmp,
  input  wire logic filter_en,
  input  wire logic window_sel,
  // Results
  output var  logic mon_a,
  output var  logic mon_b,
  output var  logic stat_upper,
  output var  logic stat_lower
);

  // ==========================================================
  // Sample and filter both comparators
  // ==========================================================
  logic [1:0]        raw;
  logic [1:0]        samp_q;
  logic [1:0]        filt_q;
  logic [FILT_W-1:0] lim;

  assign raw = {upper_cmp, lower_cmp};
  assign lim = filter_en ? FILT_ON_TICKS : FILT_OFF_TICKS;

  // Comparators are caught only on logic clock ticks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      samp_q <= 2'h0;
    end else if (logic_tick) begin
      samp_q <= raw;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic [FILT_W-1:0] cnt_q;
    logic              done;

    assign done = (cnt_q == lim - 5'h01);

    // A change must hold for lim ticks, which rejects short noise
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q     <= 5'h00;
        filt_q[i] <= 1'b0;
      end else if (logic_tick) begin
        if (samp_q[i] == filt_q[i]) begin
          cnt_q <= 5'h00;
        end else if (done) begin
          cnt_q     <= 5'h00;
          filt_q[i] <= samp_q[i];
        end else begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // ==========================================================
  // Window function and outputs
  // ==========================================================
  logic win;

  // Only meaningful when upper trip point sits above lower
  assign win = filt_q[0] & ~filt_q[1];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mon_a      <= 1'b0;
      mon_b      <= 1'b0;
      stat_upper <= 1'b0;
      stat_lower <= 1'b0;
    end else begin
      mon_a      <= window_sel ? win : filt_q[1];
      mon_b      <= filt_q[0];
      stat_upper <= filt_q[1];
      stat_lower <= filt_q[0];
    end
  end

endmodule : smc_chan

`default_nettype wire

/* File: smc_top.sv */
// Supply monitor back end: clocks, channels, readout and timers.
`default_nettype none


module smc_top
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Clock configuration switches
  input  wire logic                internal_osc_switch,
  input  wire logic                clock_pin_link_switch,
  input  wire logic                logic_clock_export_switch,
  // Shared master clock pin
  input  wire logic                shared_clock_pin_i,
  output var  logic                shared_clock_pin_o,
  output var  logic                shared_clock_pin_oe,
  // Logic clock pin and tick
  output var  logic                logic_clock_out_pin_o,
  output var  logic                logic_clock_out_pin_oe,
  output var  logic                logic_tick,
  output var  smc_pkg::smc_mode_e  clock_mode,
  // Digital inputs
  input  wire logic [smc_pkg::N_DIN-1:0] digital_in,
  output var  logic [smc_pkg::N_DIN-1:0] digital_in_q,
  // Monitor channels
  input  wire logic [smc_pkg::N_CH-1:0] upper_comparator_out,
  input  wire logic [smc_pkg::N_CH-1:0] lower_comparator_out,
  input  wire logic [smc_pkg::N_CH-1:0] filter_en,
  input  wire logic [smc_pkg::N_CH-1:0] window_sel,
  output var  logic [smc_pkg::N_CH-1:0] mon_a_out,
  output var  logic [smc_pkg::N_CH-1:0] mon_b_out,
  output var  logic [smc_pkg::N_CH-1:0] status_upper,
  output var  logic [smc_pkg::N_CH-1:0] status_lower,
  // Converter command
  input  wire logic                mux_cmd_valid,
  input  wire logic [smc_pkg::SEL_W-1:0] converter_input_select,
  input  wire logic                atten_sel,
  // Converter control and result
  output var  logic [smc_pkg::SEL_W-1:0] conv_channel,
  output var  logic                conv_atten,
  output var  logic                conv_start,
  input  wire logic                conv_done,
  input  wire logic [smc_pkg::ADC_W-1:0] conv_data,
  // Readout
  output var  logic [smc_pkg::HI_W-1:0]  reading_hi,
  output var  logic [smc_pkg::LO_W-1:0]  reading_lo,
  output var  logic                reading_new,
  output var  logic                reading_busy,
  // Timers
  input  wire logic [smc_pkg::N_TMR-1:0] timer_start,
  input  wire logic [smc_pkg::N_TMR-1:0] timer_clear,
  input  wire logic [smc_pkg::N_TMR-1:0][smc_pkg::STEP_W-1:0] timer_step,
  output var  logic [smc_pkg::N_TMR-1:0] timer_flag
);

  // ==========================================================
  // Clock mode decode
  // ==========================================================
  smc_mode_e mode;
  logic      use_ext;

  // Board-level rule: a single master drives the shared pin
  // Without the internal source the low bit flips, so slave reads 10
  assign mode = smc_mode_e'({~internal_osc_switch,
                             internal_osc_switch ~^
                             clock_pin_link_switch});
  assign use_ext = ~internal_osc_switch;

  // ==========================================================
  // Internal 8 MHz oscillator from the reference clock
  // ==========================================================
  // 250 MHz is not a whole multiple of 8 MHz, so a modulo
  // accumulator gives exactly 8 ticks per 250 cycles with jitter
  logic [OSC_W-1:0] osc_q;
  logic [OSC_W-1:0] osc_sum;
  logic             osc_wrap;
  logic [OSC_W-1:0] osc_d;

  assign osc_sum  = osc_q + OSC_STEP;
  assign osc_wrap = (osc_sum >= OSC_MOD);
  assign osc_d    = osc_wrap ? osc_sum - OSC_MOD : osc_sum;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_d;
    end
  end

  // ==========================================================
  // External clock edge and master tick
  // ==========================================================
  logic ext_q;
  logic ext_prev_q;
  logic ext_rise;
  logic mtick;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_q      <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q      <= shared_clock_pin_i;
      ext_prev_q <= ext_q;
    end
  end

  assign ext_rise = ext_q & ~ext_prev_q;
  assign mtick = use_ext ? ext_rise : osc_wrap;

  // ==========================================================
  // Divide-by-32 prescaler
  // ==========================================================
  logic [PRE_W-1:0] pre_q;
  logic             ltick;

  assign ltick = mtick & (pre_q == PRE_LAST);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
    end else if (mtick) begin
      pre_q <= pre_q + 5'h01;
    end
  end

  // ==========================================================
  // Clock pins and mode status
  // ==========================================================
  // Pin levels are registered so they never glitch on decode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shared_clock_pin_o     <= 1'b0;
      shared_clock_pin_oe    <= 1'b0;
      logic_clock_out_pin_o  <= 1'b0;
      logic_clock_out_pin_oe <= 1'b0;
      logic_tick             <= 1'b0;
      clock_mode             <= SMC_STANDALONE;
    end else begin
      shared_clock_pin_o     <= (osc_q < OSC_HALF);
      shared_clock_pin_oe    <= (mode == SMC_MASTER);
      logic_clock_out_pin_o  <= (pre_q < PRE_HALF);
      logic_clock_out_pin_oe <= logic_clock_export_switch;
      logic_tick             <= ltick;
      clock_mode             <= mode;
    end
  end

  // ==========================================================
  // Digital inputs on the master clock
  // ==========================================================
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      digital_in_q <= '0;
    end else if (mtick) begin
      digital_in_q <= digital_in;
    end
  end

  // ==========================================================
  // Monitor channels
  // ==========================================================
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    smc_chan u_chan (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .logic_tick (ltick),
      .upper_cmp  (upper_comparator_out[c]),
      .lower_cmp  (lower_comparator_out[c]),
      .filter_en  (filter_en[c]),
      .window_sel (window_sel[c]),
      .mon_a      (mon_a_out[c]),
      .mon_b      (mon_b_out[c]),
      .stat_upper (status_upper[c]),
      .stat_lower (status_lower[c])
    );
  end

  // ==========================================================
  // Converter sequencing and readout
  // ==========================================================
  smc_adc_e        adc_q;
  smc_adc_e        adc_d;
  logic            take_cmd;
  logic            take_res;
  logic [RD_W-1:0] res_ext;
  logic [RD_W-1:0] res_scaled;

  // Commands arriving during a conversion are dropped
  assign take_cmd = (adc_q == SMC_ADC_IDLE) & mux_cmd_valid;
  assign take_res = (adc_q == SMC_ADC_BUSY) & conv_done;
  assign res_ext  = {2'b00, conv_data};
  // Times three as x + 2x; fits since 3 * 1023 < 4096
  assign res_scaled = conv_atten
                    ? res_ext + {res_ext[RD_W-2:0], 1'b0}
                    : res_ext;

  always_comb begin
    adc_d = adc_q;
    case (adc_q)
      SMC_ADC_IDLE: begin
        if (take_cmd) begin
          adc_d = SMC_ADC_BUSY;
        end
      end
      SMC_ADC_BUSY: begin
        if (conv_done) begin
          adc_d = SMC_ADC_IDLE;
        end
      end
      default: begin
        adc_d = SMC_ADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_q        <= SMC_ADC_IDLE;
      conv_channel <= '0;
      conv_atten   <= 1'b0;
      conv_start   <= 1'b0;
      reading_busy <= 1'b0;
    end else begin
      adc_q        <= adc_d;
      conv_start   <= take_cmd;
      reading_busy <= (adc_d == SMC_ADC_BUSY);
      if (take_cmd) begin
        conv_channel <= converter_input_select;
        conv_atten   <= atten_sel;
      end
    end
  end

  // Both parts load in one edge so they never mix old and new
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reading_hi  <= '0;
      reading_lo  <= '0;
      reading_new <= 1'b0;
    end else begin
      reading_new <= take_res;
      if (take_res) begin
        reading_hi <= res_scaled[RD_W-1:LO_W];
        reading_lo <= res_scaled[LO_W-1:0];
      end
    end
  end

  // ==========================================================
  // Programmable timers
  // ==========================================================
  for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
    logic [TCNT_W-1:0] cnt_q;
    logic [TCNT_W-1:0] cnt_inc;
    logic [TCNT_W-1:0] lim;
    logic              run_q;
    logic              expire;

    assign lim     = smc_timeout_ticks(timer_step[t]);
    assign cnt_inc = cnt_q + 21'h000001;
    assign expire  = run_q & ltick & (cnt_inc >= lim);

    // Expiry beats a clear or restart in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q         <= '0;
        run_q         <= 1'b0;
        timer_flag[t] <= 1'b0;
      end else begin
        timer_flag[t] <= expire | (timer_flag[t] &
                         ~timer_clear[t] & ~timer_start[t]);
        run_q <= timer_start[t] |
                 (run_q & ~expire & ~timer_clear[t]);
        if (timer_start[t] | expire) begin
          cnt_q <= '0;
        end else if (run_q & ltick) begin
          cnt_q <= cnt_inc;
        end
      end
    end
  end

endmodule : smc_top

`default_nettype wire

/* File: smc_top_checker.sv */
// Port assertions for the supply monitor back end.
`default_nettype none

module smc_top_checker
  import smc_pkg::*;
(
  // Clock, reset and switches
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic internal_osc_switch,
  input wire logic clock_pin_link_switch,
  input wire logic logic_clock_export_switch,
  // Clock outputs
  input wire logic shared_clock_pin_oe,
  input wire logic logic_clock_out_pin_oe,
  input wire logic logic_tick,
  input wire smc_pkg::smc_mode_e clock_mode,
  // Channels
  input wire logic [smc_pkg::N_CH-1:0] window_sel,
  input wire logic [smc_pkg::N_CH-1:0] mon_a_out,
  input wire logic [smc_pkg::N_CH-1:0] mon_b_out,
  input wire logic [smc_pkg::N_CH-1:0] status_upper,
  input wire logic [smc_pkg::N_CH-1:0] status_lower,
  // Converter and readout
  input wire logic mux_cmd_valid,
  input wire logic [smc_pkg::SEL_W-1:0] converter_input_select,
  input wire logic [smc_pkg::SEL_W-1:0] conv_channel,
  input wire logic conv_atten,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [smc_pkg::ADC_W-1:0] conv_data,
  input wire logic [smc_pkg::HI_W-1:0] reading_hi,
  input wire logic [smc_pkg::LO_W-1:0] reading_lo,
  input wire logic reading_new,
  input wire logic reading_busy,
  // Timers
  input wire logic [smc_pkg::N_TMR-1:0] timer_start,
  input wire logic [smc_pkg::N_TMR-1:0] timer_clear,
  input wire logic [smc_pkg::N_TMR-1:0] timer_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ====================
  // Helper logic
  // Tick gap is only trusted on the internal source; an external
  // clock runs at whatever rate the board gives it
  logic [10:0]      gap_q;
  logic             seen_q;
  logic [N_TMR-1:0] keep;
  assign keep = timer_flag & ~timer_start & ~timer_clear;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_q  <= 11'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= logic_tick ? 11'h000 : gap_q + 11'h001;
      seen_q <= (logic_tick | seen_q) & ~clock_mode[1];
    end
  end

  // ====================
  // Assertions
  tick_period_a: assert property (
    logic_tick && seen_q |-> gap_q == 11'h3e7)
    else $error("logic tick spacing wrong");
  window_out_a: assert property (
    mon_a_out == ($past(window_sel) & status_lower & ~status_upper
                 | ~$past(window_sel) & status_upper))
    else $error("monitor A output wrong");
  lower_out_a: assert property (mon_b_out == status_lower)
    else $error("monitor B output wrong");
  cmd_take_a: assert property (
    mux_cmd_valid && !reading_busy |=> conv_start && reading_busy
      && conv_channel == $past(converter_input_select))
    else $error("command not taken");
  conv_result_a: assert property (
    conv_done && reading_busy |=> reading_new && {reading_hi, reading_lo}
      == ($past(conv_atten) ? 12'h003 * 12'($past(conv_data))
                            : 12'($past(conv_data))))
    else $error("stored reading wrong");
  reading_hold_a: assert property (
    !reading_new |-> $stable({reading_hi, reading_lo}))
    else $error("reading changed without a result");
  pin_drive_a: assert property (
    $past(resetn) |=> shared_clock_pin_oe == ($past(internal_osc_switch)
      & $past(clock_pin_link_switch)) && clock_mode
      == ($past(internal_osc_switch) ? {1'b0, $past(clock_pin_link_switch)}
                                     : {1'b1, ~$past(clock_pin_link_switch)}))
    else $error("clock pin mode wrong");
  clock_export_a: assert property (
    $past(resetn) |=> logic_clock_out_pin_oe
      == $past(logic_clock_export_switch))
    else $error("logic clock pin enable wrong");
  flag_hold_a: assert property (
    |keep |=> (timer_flag & $past(keep)) == $past(keep))
    else $error("timer flag dropped");

  cover property (conv_done && reading_busy && conv_atten);
  cover property (logic_tick && seen_q);
  cover property (|(window_sel & mon_a_out));
  cover property (|timer_flag);
endmodule : smc_top_checker

bind smc_top smc_top_checker chk_u (
  .ref_clk, .resetn, .internal_osc_switch, .clock_pin_link_switch,
  .logic_clock_export_switch, .shared_clock_pin_oe,
  .logic_clock_out_pin_oe, .logic_tick, .clock_mode, .window_sel,
  .mon_a_out, .mon_b_out, .status_upper, .status_lower, .mux_cmd_valid,
  .converter_input_select, .conv_channel, .conv_atten, .conv_start,
  .conv_done, .conv_data, .reading_hi, .reading_lo, .reading_new,
  .reading_busy, .timer_start, .timer_clear, .timer_flag
);

`default_nettype wire

/* File: smc_conv_model.sv */
// Converter model: answers each start pulse after a set delay.
`default_nettype none

module smc_conv_model
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // Request, delay and value
  input  wire logic                      conv_start,
  input  wire logic [7:0]                lat,
  input  wire logic [smc_pkg::ADC_W-1:0] value,
  // Result
  output var  logic                      conv_done,
  output var  logic [smc_pkg::ADC_W-1:0] conv_data
);
  logic [7:0] wait_q;
  logic       busy_q;

  // Data is valid only with done; the inverse shows otherwise, so a
  // reading latched on the wrong edge is caught
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q    <= 1'b0;
      wait_q    <= 8'h00;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else begin
      conv_done <= busy_q && wait_q == 8'h00;
      conv_data <= (busy_q && wait_q == 8'h00) ? value : ~value;
      busy_q    <= conv_start | (busy_q && wait_q != 8'h00);
      wait_q    <= conv_start ? lat : wait_q - 8'h01;
    end
  end
endmodule : smc_conv_model

`default_nettype wire

/* File: smc_top_tb.sv */
// Self-checking bench for the supply monitor back end.
`default_nettype none

module smc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;

  // ====================
  // Signals
  logic ref_clk, resetn, sw_osc, sw_link, sw_exp, ext_clk, pin_o, pin_oe;
  logic lclk_o, lclk_oe, tick, cmd, catt, conv_start, conv_atten, conv_done;
  logic rd_new, rd_busy;
  smc_mode_e mode;
  logic [N_DIN-1:0] din, din_q;
  logic [N_CH-1:0] upper, lower, fen, wsel, mon_a, mon_b, st_u, st_l;
  logic [SEL_W-1:0] csel, conv_channel;
  logic [ADC_W-1:0] conv_data, value;
  logic [HI_W-1:0] rd_hi;
  logic [LO_W-1:0] rd_lo;
  logic [7:0] lat;
  logic [N_TMR-1:0] tstart, tclr, tflag;
  logic [N_TMR-1:0][STEP_W-1:0] tstep;
  logic [RD_W-1:0] prev;
  int num_errors, num_checks;

  // Reference clock, and a board clock offset from its edges
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    ext_clk = 1'b0;
    #1;
    forever #62 ext_clk = ~ext_clk;
  end

  smc_top dut_u (
    .ref_clk, .resetn, .internal_osc_switch(sw_osc),
    .clock_pin_link_switch(sw_link), .logic_clock_export_switch(sw_exp),
    .shared_clock_pin_i(pin_oe ? pin_o : ext_clk),
    .shared_clock_pin_o(pin_o), .shared_clock_pin_oe(pin_oe),
    .logic_clock_out_pin_o(lclk_o), .logic_clock_out_pin_oe(lclk_oe),
    .logic_tick(tick), .clock_mode(mode), .digital_in(din),
    .digital_in_q(din_q), .upper_comparator_out(upper),
    .lower_comparator_out(lower), .filter_en(fen), .window_sel(wsel),
    .mon_a_out(mon_a), .mon_b_out(mon_b), .status_upper(st_u),
    .status_lower(st_l), .mux_cmd_valid(cmd), .converter_input_select(csel),
    .atten_sel(catt), .conv_channel, .conv_atten, .conv_start, .conv_done,
    .conv_data, .reading_hi(rd_hi), .reading_lo(rd_lo),
    .reading_new(rd_new), .reading_busy(rd_busy), .timer_start(tstart),
    .timer_clear(tclr), .timer_step(tstep), .timer_flag(tflag)
  );
  smc_conv_model conv_u (
    .ref_clk, .resetn, .conv_start, .lat, .value, .conv_done, .conv_data
  );

  // ====================
  // Checking and closing
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic fail();
    num_errors++;
    results();
  endtask : fail

  // ====================
  // Scenarios
  // All six comparator and select cases at once, filter off
  task automatic t_window();
    logic win;
    for (int i = 0; i < N_CH; i++) begin
      upper[i] = (i % 3) == 2;
      lower[i] = (i % 3) != 0;
    end
    wsel = 10'h2aa;
    repeat (6000) @(negedge ref_clk);
    for (int i = 0; i < N_CH; i++) begin
      win = wsel[i] ? lower[i] & ~upper[i] : upper[i];
      check(12'(mon_a[i]), 12'(win));
      check(12'(mon_b[i]), 12'(lower[i]));
      check(12'({st_u[i], st_l[i]}), 12'({upper[i], lower[i]}));
    end
  endtask : t_window

  // Same step on a filtered and an unfiltered channel, ticks counted
  task automatic t_filter();
    int n, t_on, t_off;
    fen = 10'h001;
    lower[0] = 1'b1;
    lower[3] = 1'b1;
    n = 0;
    t_on = -1;
    t_off = -1;
    for (int k = 0; k < 30000 && t_on < 0; k++) begin
      @(negedge ref_clk);
      if (st_l[3] === 1'b1 && t_off < 0) t_off = n;
      if (st_l[0] === 1'b1) t_on = n;
      n += (tick === 1'b1);
    end
    if (t_on < 0) fail();
    // The first counted tick is the one that samples the step
    check(12'(t_on - 1), 12'(FILT_ON_TICKS));
    check(12'(t_off - 1), 12'(FILT_OFF_TICKS));
  endtask : t_filter

  // One conversion, with a command refused while busy
  task automatic convert(input logic [3:0] sel, input logic at,
                         input logic [9:0] d, input logic [7:0] l);
    int k;
    value = d;
    lat = l;
    csel = sel;
    catt = at;
    cmd = 1'b1;
    @(negedge ref_clk);
    check(12'({conv_start, rd_busy}), 12'h003);
    check(12'({conv_atten, conv_channel}), 12'({at, sel}));
    csel = ~sel;
    @(negedge ref_clk);
    cmd = 1'b0;
    check(12'({conv_start, conv_channel}), 12'({1'b0, sel}));
    check({rd_hi, rd_lo}, prev);
    for (k = 0; k < 100 && rd_new !== 1'b1; k++) @(negedge ref_clk);
    if (k == 100) fail();
    prev = at ? 12'(d) * 12'h003 : 12'(d);
    check({rd_hi, rd_lo}, prev);
    check(12'(rd_busy), 12'h000);
  endtask : convert

  // Every switch setting, tick spacing and master clock rate
  task automatic t_clock();
    int gap, n, rise, lrise;
    logic last, llast;
    smc_mode_e em;
    for (int m = 0; m < 4; m++) begin
      {sw_osc, sw_link} = 2'(m);
      sw_exp = ~sw_exp;
      em = sw_osc ? (sw_link ? SMC_MASTER : SMC_STANDALONE)
                  : (sw_link ? SMC_SLAVE : SMC_NOSOURCE);
      repeat (3) @(negedge ref_clk);
      check(12'(pin_oe), 12'(sw_osc & sw_link));
      check(12'(lclk_oe), 12'(sw_exp));
      check(12'(mode), 12'(em));
      gap = 0;
      n = 0;
      rise = 0;
      lrise = 0;
      last = pin_o;
      llast = lclk_o;
      for (int k = 0; k < 3000 && n < 2; k++) begin
        @(negedge ref_clk);
        gap += (n == 1);
        rise += (n == 1 && pin_o === 1'b1 && last === 1'b0);
        lrise += (n == 1 && lclk_o === 1'b1 && llast === 1'b0);
        last = pin_o;
        llast = lclk_o;
        n += (tick === 1'b1);
      end
      if (n < 2) fail();
      check(12'(gap), sw_osc ? 12'h3e8 : 12'h3e0);
      // One logic clock period shows exactly one rise on its pin
      check(12'(lrise), 12'h001);
      if (m == 3) check(12'(rise), 12'h020);
    end
    sw_link = 1'b0;
  endtask : t_clock

  // Four timers with different steps, then clear and restart
  task automatic t_timer();
    int n, lim;
    int at [N_TMR];
    tstep = {7'h10, 7'h02, 7'h01, 7'h00};
    tstart = 4'hf;
    @(negedge ref_clk);
    tstart = 4'h0;
    n = 0;
    at = '{default: -1};
    for (int k = 0; k < 40000 && tflag !== 4'hf; k++) begin
      @(negedge ref_clk);
      for (int t = 0; t < N_TMR; t++)
        if (tflag[t] === 1'b1 && at[t] < 0) at[t] = n;
      n += (tick === 1'b1);
    end
    if (tflag !== 4'hf) fail();
    for (int t = 0; t < N_TMR; t++) begin
      lim = (int'(tstep[t][3:0]) + 1) * 8 << (2 * int'(tstep[t][6:4]));
      check(12'(at[t] + 1), 12'(lim));
    end
    tclr = 4'h2;
    tstart = 4'h1;
    @(negedge ref_clk);
    tclr = 4'h0;
    tstart = 4'h0;
    check(12'(tflag), 12'h00c);
  endtask : t_timer

  // ====================
  // Main sequence
  initial begin
    resetn = 1'b0;
    {sw_osc, sw_link, sw_exp} = 3'b100;
    {din, upper, lower, fen, wsel} = '0;
    {cmd, catt, csel, tstart, tclr, tstep, lat, value, prev} = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    din = 4'ha;
    repeat (40) @(negedge ref_clk);
    check(12'(din_q), 12'h00a);
    t_window();
    t_filter();
    convert(4'h5, 1'b1, 10'h3ff, 8'h00);
    convert(4'h9, 1'b0, 10'h155, 8'h0c);
    convert(4'h0, 1'b1, 10'h001, 8'h03);
    t_clock();
    t_timer();
    results();
  end
endmodule : smc_top_tb

`default_nettype wire
